// ==== common/otpdec_pkg.sv ====
// Package for the option-byte decoder: option area layout, reset values,
// stabilization wait codes and the decoded configuration record.
// Assumes a byte-wide PROM with a 15-bit address and one-cycle read latency.
package otpdec_pkg;

  // Option area placement in the PROM
  localparam logic [14:0] OPT_BASE     = 15'h3FF0;
  localparam int          OPT_COUNT    = 7;
  localparam logic [2:0]  OPT_LAST_IDX = 3'h6;

  // Every option bit reads as one while blank
  localparam logic [7:0]  OPT_BLANK    = 8'hFF;

  // Field positions in the first option byte
  localparam int          CLK_SYS_BIT  = 4;
  localparam int          POR_EN_BIT   = 2;
  localparam int          WAIT_LSB     = 0;

  // Operating program region folding: C000..FFFF sits at 4000..7FFF
  localparam logic        FOLD_A14     = 1'b1;

  // Stabilization wait codes
  typedef enum logic [1:0] {
    OTPDEC_WAIT_2E18 = 2'h0,
    OTPDEC_WAIT_2E17 = 2'h1,
    OTPDEC_WAIT_2E13 = 2'h2,
    OTPDEC_WAIT_NONE = 2'h3
  } otpdec_wait_t;

  // Wait lengths in main clock periods (main_clock_frequency periods)
  localparam int          WAIT_2E18_CYC = 262144;
  localparam int          WAIT_2E17_CYC = 131072;
  localparam int          WAIT_2E13_CYC = 8192;
  localparam int          WAIT_CNT_W    = 19;

  // Decoded static configuration
  typedef struct packed {
    logic         dual_clock;
    logic         por_enable;
    otpdec_wait_t wait_sel;
    logic [7:0]   pu_port0;
    logic [7:0]   pu_port1;
    logic [4:0]   pu_port2;
    logic [7:0]   pu_port3;
    logic [7:0]   pu_port4;
    logic [7:0]   pu_port5;
  } otpdec_cfg_t;

endpackage : otpdec_pkg

// ==== hdl/otpdec_top.sv ====
// Option-byte decoder: loads the option area after reset, decodes it into
// static configuration, folds addresses onto the PROM and times the
// oscillation stabilization wait.
// Assumes the PROM answers one cycle after its address; programmer pins are
// asynchronous and are synchronized here.
`timescale 1ns/100ps

// Functional notes
// - Operating mode maps C000-FFFF to 4000-7FFF
// - Byte0 bit4 dual clock, bit2 power-on reset
// - Pull-up bit one disables, zero enables
// - Blank option bits read as one
// - No electronic signature read in EPROM mode
// - Wait applies after power-on reset (only with byte0 bit2 set) and stop wake
module otpdec_top #(
  parameter int WAIT_LONG  = otpdec_pkg::WAIT_2E18_CYC,
  parameter int WAIT_MID   = otpdec_pkg::WAIT_2E17_CYC,
  parameter int WAIT_SHORT = otpdec_pkg::WAIT_2E13_CYC
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  // PROM array port
  output logic [14:0]                  prom_addr_o,
  output logic                         prom_rd_o,
  input  wire logic [7:0]              prom_data_i,
  // CPU fetch side
  input  wire logic [15:0]             cpu_addr_i,
  input  wire logic                    cpu_rd_i,
  output logic [7:0]                   cpu_data_o,
  // Programmer pins in EPROM mode
  input  wire logic                    epm_mode_i,
  input  wire logic [14:0]             prg_addr_i,
  input  wire logic                    prg_rd_i,
  input  wire logic                    sig_req_i,
  output logic [7:0]                   prg_data_o,
  output logic                         prg_data_oe_o,
  // Clock and reset controller
  input  wire logic                    por_flag_i,
  input  wire logic                    stop_wake_i,
  output logic                         osc_ready_o,
  // Decoded configuration and raw read-back
  output otpdec_pkg::otpdec_cfg_t      cfg_o,
  output logic [8*otpdec_pkg::OPT_COUNT-1:0] opt_bytes_o,
  output logic                         cfg_valid_o
);

  typedef enum logic [1:0] {ST_ISSUE, ST_CAPT, ST_DONE} otpdec_state_t;

  otpdec_state_t                       state_r;
  logic [2:0]                          idx_r;
  logic [7:0]                          opt_r [otpdec_pkg::OPT_COUNT];
  logic                                done;
  logic [otpdec_pkg::WAIT_CNT_W-1:0]   wait_r;
  logic                                start_wait;
  logic [otpdec_pkg::WAIT_CNT_W-1:0]   wait_len;
  logic                                epm_s1_r, epm_s2_r, prd_s1_r, prd_s2_r;
  logic                                sig_s1_r, sig_s2_r;
  logic [14:0]                         pad_s1_r, pad_s2_r, pad_s3_r;
  logic                                rst_seen_r;

  assign done = (state_r == ST_DONE);

  ////////////////////////////////////////////////////////////////////////////
  // Programmer pin synchronizers
  always_ff @(posedge clk_i) begin
    epm_s1_r <= epm_mode_i;
    epm_s2_r <= epm_s1_r;
    prd_s1_r <= prg_rd_i;
    prd_s2_r <= prd_s1_r;
    sig_s1_r <= sig_req_i;
    sig_s2_r <= sig_s1_r;
    pad_s1_r <= prg_addr_i;
    pad_s2_r <= pad_s1_r;
    pad_s3_r <= pad_s2_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loader: one address, one capture, per option byte; runs once per reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_r <= ST_ISSUE;
      idx_r   <= 3'h0;
    end else begin
      unique case (state_r)
        ST_ISSUE: state_r <= ST_CAPT;
        ST_CAPT: begin
          if (idx_r == otpdec_pkg::OPT_LAST_IDX) begin
            state_r <= ST_DONE;
          end else begin
            idx_r   <= idx_r + 3'h1;
            state_r <= ST_ISSUE;
          end
        end
        ST_DONE: state_r <= ST_DONE;
      endcase
    end
  end

  // Option storage; blank until the loader fills it, never written after
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < otpdec_pkg::OPT_COUNT; i++) begin
        opt_r[i] <= otpdec_pkg::OPT_BLANK;
      end
    end else if (state_r == ST_CAPT) begin
      opt_r[idx_r] <= prom_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PROM address source: loader first, then programmer or CPU
  always_comb begin
    prom_addr_o = otpdec_pkg::OPT_BASE + {12'h000, idx_r};
    prom_rd_o   = (state_r == ST_ISSUE);
    if (done) begin
      if (epm_s2_r) begin
        prom_addr_o = pad_s2_r;
        prom_rd_o   = prd_s2_r;
      end else begin
        prom_addr_o = {otpdec_pkg::FOLD_A14, cpu_addr_i[13:0]};
        prom_rd_o   = cpu_rd_i;
      end
    end
  end

  // Read data returns one cycle later; registered toward each party
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cpu_data_o    <= 8'h00;
      prg_data_o    <= 8'h00;
      prg_data_oe_o <= 1'b0;
    end else begin
      cpu_data_o    <= prom_data_i;
      prg_data_o    <= prom_data_i;
      // A signature request holds the output enable low: no identification is driven
      // Address bits are synced one by one and may skew: drive once they agree twice
      prg_data_oe_o <= done && epm_s2_r && prd_s2_r && !sig_s2_r
                       && (pad_s2_r == pad_s3_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded configuration; inverted pull-up sense so one means enabled
  generate
    for (genvar b = 0; b < otpdec_pkg::OPT_COUNT; b++) begin : g_rb
      assign opt_bytes_o[8*b +: 8] = opt_r[b];
    end
  endgenerate

  assign cfg_o.dual_clock = opt_r[0][otpdec_pkg::CLK_SYS_BIT];
  assign cfg_o.por_enable = opt_r[0][otpdec_pkg::POR_EN_BIT];
  assign cfg_o.wait_sel   =
      otpdec_pkg::otpdec_wait_t'(opt_r[0][otpdec_pkg::WAIT_LSB +: 2]);
  assign cfg_o.pu_port0   = ~opt_r[1];
  // Port 1 pairs and port 4 quads share one bit each
  assign cfg_o.pu_port1   = ~{{2{opt_r[2][3]}}, {2{opt_r[2][2]}},
                              {2{opt_r[2][1]}}, {2{opt_r[2][0]}}};
  assign cfg_o.pu_port4   = ~{{4{opt_r[2][5]}}, {4{opt_r[2][4]}}};
  assign cfg_o.pu_port3   = ~opt_r[3];
  assign cfg_o.pu_port5   = ~opt_r[4];
  assign cfg_o.pu_port2   = ~opt_r[5][4:0];
  assign cfg_valid_o      = done;

  ////////////////////////////////////////////////////////////////////////////
  // Stabilization wait; the wait runs even with an external clock source
  always_comb begin
    unique case (cfg_o.wait_sel)
      otpdec_pkg::OTPDEC_WAIT_2E18: wait_len = WAIT_LONG[otpdec_pkg::WAIT_CNT_W-1:0];
      otpdec_pkg::OTPDEC_WAIT_2E17: wait_len = WAIT_MID[otpdec_pkg::WAIT_CNT_W-1:0];
      otpdec_pkg::OTPDEC_WAIT_2E13: wait_len = WAIT_SHORT[otpdec_pkg::WAIT_CNT_W-1:0];
      otpdec_pkg::OTPDEC_WAIT_NONE: wait_len = '0;
    endcase
  end

  // Start at load completion after power-on reset with byte 0 bit 2 set, or on stop wake
  // Byte 0 is already stored when the last byte arrives; the last byte is vacant
  assign start_wait = (state_r == ST_CAPT && idx_r == otpdec_pkg::OPT_LAST_IDX
                       && por_flag_i && opt_r[0][otpdec_pkg::POR_EN_BIT])
                      || (done && stop_wake_i);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wait_r <= '0;
    end else if (start_wait) begin
      wait_r <= wait_len;
    end else if (wait_r != '0) begin
      wait_r <= wait_r - 1'b1;
    end
  end

  assign osc_ready_o = done && (wait_r == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i || !rst_seen_r);

  // Checks wake one edge after release: at the release edge the loader is still reset
  always_ff @(posedge clk_i) begin
    rst_seen_r <= rst_b_i;
  end

  sequence s_issue; state_r == ST_ISSUE; endsequence
  sequence s_capt;  state_r == ST_CAPT;  endsequence
  sequence s_next;  (state_r == ST_ISSUE) || (state_r == ST_DONE); endsequence

  a_load_order: assert property (s_issue |=> s_capt ##1 s_next)
    else $error("loader left issue-capture order");
  a_cfg_hold: assert property (done && $past(done) |-> $stable(opt_bytes_o))
    else $error("options changed after loading");
  a_fold_map: assert property (done && !epm_s2_r |->
      prom_addr_o == {1'b1, cpu_addr_i[13:0]})
    else $error("operating address not folded");
  a_clock_por: assert property (s_capt and (idx_r == 3'h0) |=>
      cfg_o.dual_clock == $past(prom_data_i[4])
      && cfg_o.por_enable == $past(prom_data_i[2]))
    else $error("clock or reset option misdecoded");
  a_wait_len: assert property (start_wait && opt_bytes_o[1:0] == 2'h2 |=>
      wait_r == WAIT_SHORT[otpdec_pkg::WAIT_CNT_W-1:0])
    else $error("wait length wrong");
  a_pullup_sense: assert property (s_capt and (idx_r == 3'h2) |=>
      cfg_o.pu_port0 == ~$past(prom_data_i, 3)
      && cfg_o.pu_port4[7] == !$past(prom_data_i[5])
      && cfg_o.pu_port1[0] == !$past(prom_data_i[0]))
    else $error("pull-up sense wrong");
  a_blank_ones: assert property (s_issue and (idx_r == 3'h0) |->
      opt_bytes_o == {otpdec_pkg::OPT_COUNT{8'hFF}})
    else $error("blank options not all ones");
  a_no_signature: assert property (sig_s2_r |=> !prg_data_oe_o)
    else $error("signature read answered");
  a_wake_wait: assert property (done && stop_wake_i && opt_bytes_o[1:0] != 2'h3
      |=> !osc_ready_o [*3])
    else $error("stop wake skipped the wait");
  a_vacant_keep: assert property (s_capt and (idx_r == 3'h6) |=>
      opt_bytes_o[55:48] == $past(prom_data_i))
    else $error("vacant byte not stored");

endmodule : otpdec_top

// ==== bench/otpdec_prom_model.sv ====
// PROM array model: byte wide, data one edge after a read address.
// Assumes the bench fills mem before reset is released.
`timescale 1ns/100ps
module otpdec_prom_model (
  // Clock
  input  wire logic        clk_i,
  // Array port
  input  wire logic [14:0] addr_i,
  input  wire logic        rd_i,
  output logic [7:0]       data_o
);
  logic [7:0] mem [0:32767];
  logic [7:0] last_r = 8'h0;
  // Idle cycles show the inverse so a stale byte never passes as fresh
  always @(posedge clk_i) begin
    if (rd_i) begin
      data_o <= mem[addr_i];
      last_r <= mem[addr_i];
    end else begin
      data_o <= ~last_r;
    end
  end
endmodule : otpdec_prom_model

// ==== bench/tb_top.sv ====
// Bench for the option decoder: option images, waits, folding, programmer.
// Assumes the PROM model and shortened wait parameters.
`timescale 1ns/100ps
module tb_top;
  localparam int WL = 64, WM = 32, WS = 8;
  logic        clk_i = 1'h0, rst_b_i = 1'h0, cpu_rd_i = 1'h0, epm_mode_i = 1'h0;
  logic        prg_rd_i = 1'h0, sig_req_i = 1'h0, por_flag_i = 1'h0, stop_wake_i = 1'h0;
  logic [15:0] cpu_addr_i = 16'h0;
  logic [14:0] prg_addr_i = 15'h0, prom_addr_o;
  logic [7:0]  prom_data_i, cpu_data_o, prg_data_o;
  logic        prom_rd_o, prg_data_oe_o, osc_ready_o, cfg_valid_o;
  logic [55:0] opt_bytes_o;
  logic [15:0] ca [3] = '{16'hC123, 16'hFFFF, 16'hC000};
  otpdec_pkg::otpdec_cfg_t cfg_o;
  int          errors = 0, checks_done = 0, n;
  ////////////////////////////////////////////////////////////////////////////
  always #5 clk_i = ~clk_i;
  otpdec_top #(.WAIT_LONG(WL), .WAIT_MID(WM), .WAIT_SHORT(WS)) DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .prom_addr_o(prom_addr_o), .prom_rd_o(prom_rd_o),
    .prom_data_i(prom_data_i), .cpu_addr_i(cpu_addr_i), .cpu_rd_i(cpu_rd_i),
    .cpu_data_o(cpu_data_o), .epm_mode_i(epm_mode_i), .prg_addr_i(prg_addr_i),
    .prg_rd_i(prg_rd_i), .sig_req_i(sig_req_i), .prg_data_o(prg_data_o),
    .prg_data_oe_o(prg_data_oe_o), .por_flag_i(por_flag_i), .stop_wake_i(stop_wake_i),
    .osc_ready_o(osc_ready_o), .cfg_o(cfg_o), .opt_bytes_o(opt_bytes_o),
    .cfg_valid_o(cfg_valid_o));
  otpdec_prom_model prom (.clk_i(clk_i), .addr_i(prom_addr_o), .rd_i(prom_rd_o),
    .data_o(prom_data_i));
  ////////////////////////////////////////////////////////////////////////////
  // Expected decode; pull-up outputs are enables, so option bits invert
  function automatic otpdec_pkg::otpdec_cfg_t exp_cfg(input logic [55:0] o);
    otpdec_pkg::otpdec_cfg_t c;
    c.dual_clock = o[4];
    c.por_enable = o[2];
    c.wait_sel = otpdec_pkg::otpdec_wait_t'(o[1:0]);
    c.pu_port0 = ~o[15:8];
    for (int i = 0; i < 8; i++) begin
      c.pu_port1[i] = ~o[16 + i / 2];
    end
    c.pu_port4 = {{4{~o[21]}}, {4{~o[20]}}};
    c.pu_port3 = ~o[31:24];
    c.pu_port5 = ~o[39:32];
    c.pu_port2 = ~o[44:40];
    return c;
  endfunction : exp_cfg
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Counts are exact: the wait starts at the edge that ends the load or takes the wake
  task automatic chk_cnt(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      errors++;
      $display("MISMATCH t=%0t wait %0d cycles exp %0d", $time, got, exp);
    end
  endtask : chk_cnt
  task automatic load(input logic [55:0] o, input logic por);
    int k;
    for (k = 0; k < 7; k++) begin
      prom.mem[otpdec_pkg::OPT_BASE + k] = o[8*k +: 8];
    end
    @(posedge clk_i);
    rst_b_i <= 1'h0;
    por_flag_i <= por;
    repeat (6) @(posedge clk_i);
    chk(64'(cfg_o), 64'(exp_cfg({7{8'hFF}})), "reset decode");
    chk(64'(cfg_valid_o), 64'h0, "valid in reset");
    rst_b_i <= 1'h1;
    k = 0;
    while (cfg_valid_o !== 1'h1 && k < 30) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk(64'(k), 64'hE, "load cycles");
    chk(64'(opt_bytes_o), 64'(o), "raw bytes");
    chk(64'(cfg_o), 64'(exp_cfg(o)), "decode");
  endtask : load
  task automatic wait_low(output int cnt);
    cnt = 0;
    repeat (3) begin
      if (osc_ready_o === 1'h1) begin
        @(posedge clk_i);
        #1;
      end
    end
    while (osc_ready_o !== 1'h1 && cnt < 300) begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
  endtask : wait_low
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized for six loads plus the longest waits
  initial begin
    #300000;
    errors++;
    summarize();
  end
  initial begin
    for (int a = 0; a < 32768; a++) begin
      prom.mem[a] = 8'(a ^ (a >> 7));
    end
    load({7{8'hFF}}, 1'h1);
    wait_low(n);
    chk_cnt(n, 0);
    for (int c = 0; c < 3; c++) begin
      load({48'hFFFFFFFFFFFF, 6'h3F, 2'(c)}, 1'h1);
      wait_low(n);
      chk_cnt(n, c == 0 ? WL : c == 1 ? WM : WS);
    end
    load({48'hFFFFFFFFFFFF, 6'h3F, 2'h0}, 1'h0);
    wait_low(n);
    chk_cnt(n, 0);
    $display("test waits done");
    load(56'h5AEA813CD6A5E2, 1'h1);
    wait_low(n);
    chk_cnt(n, 0);
    @(posedge clk_i);
    stop_wake_i <= 1'h1;
    @(posedge clk_i);
    stop_wake_i <= 1'h0;
    #1 wait_low(n);
    chk_cnt(n, WS);
    $display("test options done");
    for (int k = 0; k < 7; k++) begin
      prom.mem[otpdec_pkg::OPT_BASE + k] = 8'h0;
    end
    foreach (ca[i]) begin
      @(posedge clk_i);
      cpu_addr_i <= ca[i];
      cpu_rd_i <= 1'h1;
      @(negedge clk_i);
      chk(64'(prom_addr_o), 64'({1'h1, ca[i][13:0]}), "fold");
      @(posedge clk_i);
      cpu_rd_i <= 1'h0;
      @(posedge clk_i);
      #1 chk(64'(cpu_data_o), 64'(prom.mem[{1'h1, ca[i][13:0]}]), "fetch");
    end
    $display("test fold done");
    @(posedge clk_i);
    epm_mode_i <= 1'h1;
    prg_addr_i <= 15'h4ABC;
    prg_rd_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    #1 chk(64'({prg_data_oe_o, prg_data_o}), 64'({1'h1, prom.mem[15'h4ABC]}), "prog");
    @(posedge clk_i);
    sig_req_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    #1 chk(64'(prg_data_oe_o), 64'h0, "signature");
    chk(64'(cfg_o), 64'(exp_cfg(56'h5AEA813CD6A5E2)), "held");
    $display("test programmer done");
    summarize();
  end
endmodule : tb_top
